// *** rtl/cnc_node.sv ***
`timescale 1ns/100ps
`default_nettype none
module cnc_node
  import cnc_pkg::*;
#(
  parameter logic [31:0] VENDOR_ID = 32'h0000_0a5a, // Arbitrary value
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0101, // Arbitrary value
  parameter logic [31:0] REVISION = 32'h0001_0000, // Arbitrary value
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Product serial, part after the hyphen
  input wire logic [31:0] i_serial,
  // Network management command
  input wire logic i_nmt_valid,
  input wire logic [7:0] i_nmt_cmd,
  input wire logic [6:0] i_nmt_node,
  // Layer setting command and answer
  input wire logic i_lss_valid,
  input wire logic [7:0] i_lss_cmd,
  input wire logic [31:0] i_lss_data,
  output logic o_lss_ack,
  output logic [7:0] o_lss_status,
  // Object service request from the bus
  input wire logic i_srv_valid,
  input wire logic [1:0] i_srv_kind,
  input wire logic [31:0] i_srv_data,
  output logic o_srv_ack,
  output logic o_srv_refused,
  // Measurements to transmit, through the FIFO
  input wire logic i_meas_valid,
  output logic o_meas_ready,
  input wire logic [31:0] i_meas_data,
  output logic o_tpdo_valid,
  input wire logic i_tpdo_ready,
  output logic [31:0] o_tpdo_data,
  // Set points received
  output logic o_setp_valid,
  output logic [31:0] o_setp_data,
  // SDO request handed to the application
  output logic o_sdo_valid,
  output logic [31:0] o_sdo_data,
  // Node status
  output logic [1:0] o_state,
  output logic o_lss_config,
  output logic [6:0] o_node_id,
  output logic [3:0] o_bit_idx,
  output logic [9:0] o_rate_kbps
);
  import cnc_pkg::*;

  cnc_state_e st_q, st_d;
  cnc_lss_e lss_q, lss_d;
  logic [4:0] init_cnt_q, init_cnt_d;
  logic [6:0] id_q, id_d, id_pend_q, id_pend_d;
  logic [3:0] bi_q, bi_d, bi_pend_q, bi_pend_d;
  logic [3:0] match_q, match_d;
  logic ack_q, ack_d;
  logic [7:0] stat_q, stat_d;
  logic sack_q, sack_d, sref_q, sref_d;
  logic setp_v_q, setp_v_d, sdo_v_q, sdo_v_d;
  logic [31:0] setp_q, setp_d, sdo_q, sdo_d;
  logic [9:0] rate_q, rate_w;
  logic fifo_valid, fifo_in_ready;
  logic [31:0] fifo_data;
  logic tpdo_go;
  logic nmt_hit;

  // Is this service allowed in the given node state
  function automatic logic srv_allowed(input cnc_state_e s, input logic [1:0] k);
    case (s)
      CNC_PREOP: srv_allowed = (k == SRV_SDO);
      CNC_OPER: srv_allowed = (k != SRV_REMAP);
      default: srv_allowed = 1'b0;
    endcase
  endfunction

  // Node management commands address this node or all nodes
  assign nmt_hit = i_nmt_valid && (i_nmt_node == id_q || i_nmt_node == 7'h00);

  // Node state machine
  always_comb begin
    st_d = st_q;
    init_cnt_d = init_cnt_q;
    case (st_q)
      CNC_INIT: begin
        // Init leaves only when its own work is done
        if (init_cnt_q == INIT_CNT_LAST) begin
          st_d = CNC_PREOP;
          init_cnt_d = '0;
        end else begin
          init_cnt_d = init_cnt_q + 5'h01;
        end
      end
      CNC_PREOP, CNC_OPER, CNC_STOPPED: begin
        if (nmt_hit) begin
          case (i_nmt_cmd)
            NMT_START: st_d = CNC_OPER;
            NMT_STOP: st_d = CNC_STOPPED;
            NMT_PREOP: st_d = CNC_PREOP;
            NMT_RESET_NODE, NMT_RESET_COMM: st_d = CNC_INIT;
            default: st_d = st_q;
          endcase
        end
      end
      default: st_d = CNC_INIT;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_q <= CNC_INIT;
      init_cnt_q <= '0;
    end else begin
      st_q <= st_d;
      init_cnt_q <= init_cnt_d;
    end
  end

  // Layer setting: global switch or identity match, then configure; new values apply on store
  always_comb begin
    lss_d = lss_q;
    id_d = id_q;
    bi_d = bi_q;
    id_pend_d = id_pend_q;
    bi_pend_d = bi_pend_q;
    match_d = match_q;
    ack_d = 1'b0;
    stat_d = stat_q;
    if (i_lss_valid) begin
      case (i_lss_cmd)
        LSS_SWITCH_GLOBAL: begin
          lss_d = (i_lss_data[7:0] == LSS_MODE_CONFIG) ? CNC_LSS_CONFIG : CNC_LSS_WAIT;
          match_d = '0;
        end
        // Selective switch: all four identity fields must match in order
        LSS_SEL_VENDOR: match_d = {3'h0, i_lss_data == VENDOR_ID};
        LSS_SEL_PRODUCT: match_d = {2'h0, match_q[0] && i_lss_data == PRODUCT_CODE, match_q[0]};
        LSS_SEL_REVISION: match_d = {1'b0, match_q[1] && i_lss_data == REVISION, match_q[1:0]};
        LSS_SEL_SERIAL: begin
          match_d = '0;
          if (match_q[2] && i_lss_data == i_serial) begin
            lss_d = CNC_LSS_CONFIG;
            ack_d = 1'b1;
            stat_d = LSS_ACK_OK;
          end
        end
        LSS_CFG_NODE_ID: if (lss_q == CNC_LSS_CONFIG) begin
          ack_d = 1'b1;
          if (i_lss_data[6:0] >= NODE_ID_MIN && i_lss_data[6:0] <= NODE_ID_MAX
              && i_lss_data[31:7] == '0) begin
            id_pend_d = i_lss_data[6:0];
            stat_d = LSS_ACK_OK;
          end else begin
            stat_d = LSS_ACK_BAD;
          end
        end
        LSS_CFG_BIT_TIMING: if (lss_q == CNC_LSS_CONFIG) begin
          ack_d = 1'b1;
          if (i_lss_data[31:4] == '0 && i_lss_data[3:0] <= BIT_IDX_MAX) begin
            bi_pend_d = i_lss_data[3:0];
            stat_d = LSS_ACK_OK;
          end else begin
            stat_d = LSS_ACK_BAD;
          end
        end
        LSS_STORE: if (lss_q == CNC_LSS_CONFIG) begin
          ack_d = 1'b1;
          stat_d = LSS_ACK_OK;
          id_d = id_pend_q;
          bi_d = bi_pend_q;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      lss_q <= CNC_LSS_WAIT;
      id_q <= NODE_ID_DEFAULT;
      bi_q <= BIT_IDX_10K;
      id_pend_q <= NODE_ID_DEFAULT;
      bi_pend_q <= BIT_IDX_10K;
      match_q <= '0;
      ack_q <= 1'b0;
      stat_q <= LSS_ACK_OK;
    end else begin
      lss_q <= lss_d;
      id_q <= id_d;
      bi_q <= bi_d;
      id_pend_q <= id_pend_d;
      bi_pend_q <= bi_pend_d;
      match_q <= match_d;
      ack_q <= ack_d;
      stat_q <= stat_d;
    end
  end

  // Object service gate; every request gets ack or refusal one cycle later
  always_comb begin
    sack_d = 1'b0;
    sref_d = 1'b0;
    setp_v_d = 1'b0;
    sdo_v_d = 1'b0;
    setp_d = setp_q;
    sdo_d = sdo_q;
    // A transmit request has no inbound payload; it is refused in every state
    if (i_srv_valid) begin
      if (srv_allowed(st_q, i_srv_kind) && i_srv_kind != SRV_TPDO) begin
        sack_d = 1'b1;
        if (i_srv_kind == SRV_RPDO) begin
          setp_v_d = 1'b1;
          setp_d = i_srv_data;
        end else begin
          sdo_v_d = 1'b1;
          sdo_d = i_srv_data;
        end
      end else begin
        sref_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sack_q <= 1'b0;
      sref_q <= 1'b0;
      setp_v_q <= 1'b0;
      sdo_v_q <= 1'b0;
      setp_q <= '0;
      sdo_q <= '0;
      rate_q <= 10'h00a;
    end else begin
      sack_q <= sack_d;
      sref_q <= sref_d;
      setp_v_q <= setp_v_d;
      sdo_v_q <= sdo_v_d;
      setp_q <= setp_d;
      sdo_q <= sdo_d;
      rate_q <= rate_w;
    end
  end

  // Outbound measurements flow only in Operational; FIFO holds them otherwise
  assign tpdo_go = (st_q == CNC_OPER) && i_tpdo_ready;

  cnc_fifo #(
    .WIDTH(32),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_valid(i_meas_valid),
    .o_ready(fifo_in_ready),
    .i_data(i_meas_data),
    .o_valid(fifo_valid),
    .i_ready(tpdo_go),
    .o_data(fifo_data)
  );

  cnc_rate u_rate (
    .i_bit_idx(bi_q),
    .o_rate_kbps(rate_w)
  );

  // FIFO outputs are flip-flop fed already inside the FIFO
  assign o_meas_ready = fifo_in_ready;
  assign o_tpdo_valid = fifo_valid && (st_q == CNC_OPER);
  assign o_tpdo_data = fifo_data;
  assign o_lss_ack = ack_q;
  assign o_lss_status = stat_q;
  assign o_srv_ack = sack_q;
  assign o_srv_refused = sref_q;
  assign o_setp_valid = setp_v_q;
  assign o_setp_data = setp_q;
  assign o_sdo_valid = sdo_v_q;
  assign o_sdo_data = sdo_q;
  assign o_state = st_q;
  assign o_lss_config = (lss_q == CNC_LSS_CONFIG);
  assign o_node_id = id_q;
  assign o_bit_idx = bi_q;
  assign o_rate_kbps = rate_q;
endmodule // cnc_node
`default_nettype wire

// *** rtl/cnc_pkg.sv ***
package cnc_pkg;
  // Network management command specifiers, as carried in the first byte
  localparam logic [7:0] NMT_START = 8'h01;
  localparam logic [7:0] NMT_STOP = 8'h02;
  localparam logic [7:0] NMT_PREOP = 8'h80;
  localparam logic [7:0] NMT_RESET_NODE = 8'h81;
  localparam logic [7:0] NMT_RESET_COMM = 8'h82;
  // Layer setting command specifiers
  localparam logic [7:0] LSS_SWITCH_GLOBAL = 8'h04;
  localparam logic [7:0] LSS_CFG_NODE_ID = 8'h11;
  localparam logic [7:0] LSS_CFG_BIT_TIMING = 8'h13;
  localparam logic [7:0] LSS_STORE = 8'h17;
  localparam logic [7:0] LSS_SEL_VENDOR = 8'h40;
  localparam logic [7:0] LSS_SEL_PRODUCT = 8'h41;
  localparam logic [7:0] LSS_SEL_REVISION = 8'h42;
  localparam logic [7:0] LSS_SEL_SERIAL = 8'h43;
  localparam logic [7:0] LSS_MODE_WAIT = 8'h00;
  localparam logic [7:0] LSS_MODE_CONFIG = 8'h01;
  // Node address and rate defaults and limits
  localparam logic [6:0] NODE_ID_DEFAULT = 7'h70;
  localparam logic [6:0] NODE_ID_MIN = 7'h01;
  localparam logic [6:0] NODE_ID_MAX = 7'h7f;
  localparam logic [3:0] BIT_IDX_1M = 4'h0;
  localparam logic [3:0] BIT_IDX_10K = 4'h8;
  localparam logic [3:0] BIT_IDX_MAX = 4'h8;
  // Answer status codes
  localparam logic [7:0] LSS_ACK_OK = 8'h00;
  localparam logic [7:0] LSS_ACK_BAD = 8'h01;
  // Object service kinds on the request port
  localparam logic [1:0] SRV_SDO = 2'h0;
  localparam logic [1:0] SRV_TPDO = 2'h1;
  localparam logic [1:0] SRV_RPDO = 2'h2;
  localparam logic [1:0] SRV_REMAP = 2'h3;
  // Init completion time
  localparam int INIT_CYCLES = 16;
  localparam logic [4:0] INIT_CNT_LAST = 5'h0f;
  // Node states
  typedef enum logic [1:0] {CNC_INIT, CNC_PREOP, CNC_OPER, CNC_STOPPED} cnc_state_e;
  typedef enum logic {CNC_LSS_WAIT, CNC_LSS_CONFIG} cnc_lss_e;
endpackage

// *** rtl/cnc_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
// Small synchronous FIFO; storage is flip-flops indexed by pointer
module cnc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  // Pointer and count update; full blocks push so the source stalls
  always_comb begin
    push = i_valid && (cnt_q != AW'(0) + (AW+1)'(DEPTH));
    pop = i_ready && (cnt_q != '0);
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    mem_d = mem_q;
    if (push) begin
      mem_d[wr_q] = i_data;
      wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
    end
    if (pop) begin
      rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
    end
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end

  // Registers only
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

  assign o_ready = (cnt_q != (AW+1)'(DEPTH));
  assign o_valid = (cnt_q != '0);
  assign o_data = mem_q[rd_q];
endmodule // cnc_fifo
`default_nettype wire

// *** rtl/cnc_rate.sv ***
`timescale 1ns/100ps
`default_nettype none
// Maps the bit-timing index to a bus rate in kbit/s; unknown indices read zero
module cnc_rate (
  // Index in
  input wire logic [3:0] i_bit_idx,
  // Rate out
  output logic [9:0] o_rate_kbps
);
  always_comb begin
    case (i_bit_idx)
      4'h0: o_rate_kbps = 10'h3e8;
      4'h1: o_rate_kbps = 10'h320;
      4'h2: o_rate_kbps = 10'h1f4;
      4'h3: o_rate_kbps = 10'h0fa;
      4'h4: o_rate_kbps = 10'h07d;
      4'h5: o_rate_kbps = 10'h064;
      4'h6: o_rate_kbps = 10'h032;
      4'h7: o_rate_kbps = 10'h014;
      4'h8: o_rate_kbps = 10'h00a;
      default: o_rate_kbps = 10'h000;
    endcase
  end
endmodule // cnc_rate
`default_nettype wire

// *** sim/cnc_node_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
// Port-level checks on the node; one clock domain, so shared clocking and reset
module cnc_node_monitor
  import cnc_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Requests
  input wire logic i_nmt_valid,
  input wire logic [7:0] i_nmt_cmd,
  input wire logic [6:0] i_nmt_node,
  input wire logic i_lss_valid,
  input wire logic [7:0] i_lss_cmd,
  input wire logic [31:0] i_lss_data,
  input wire logic i_srv_valid,
  input wire logic [1:0] i_srv_kind,
  input wire logic [31:0] i_srv_data,
  // Answers and status
  input wire logic o_lss_ack,
  input wire logic o_srv_ack,
  input wire logic o_srv_refused,
  input wire logic o_setp_valid,
  input wire logic [31:0] o_setp_data,
  input wire logic o_sdo_valid,
  input wire logic o_tpdo_valid,
  input wire logic [1:0] o_state,
  input wire logic o_lss_config,
  input wire logic [6:0] o_node_id,
  input wire logic [3:0] o_bit_idx,
  input wire logic [9:0] o_rate_kbps
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Layer setting steps
  sequence s_to_cfg;
    i_lss_valid && i_lss_cmd == LSS_SWITCH_GLOBAL && i_lss_data[7:0] == LSS_MODE_CONFIG;
  endsequence
  sequence s_store;
    i_lss_valid && i_lss_cmd == LSS_STORE && o_lss_config;
  endsequence
  AST_INIT_EXIT: assert property (o_state == 2'h0 ##1 o_state != 2'h0 |-> o_state == 2'h1)
    else $error("init left wrongly");
  AST_START: assert property (i_nmt_valid && i_nmt_cmd == NMT_START && o_state != 2'h0 &&
    (i_nmt_node == 7'h00 || i_nmt_node == o_node_id) |=> o_state == 2'h2)
    else $error("start ignored");
  AST_HOLD_STATE: assert property (o_state != 2'h0 && !i_nmt_valid |=> $stable(o_state))
    else $error("state moved by itself");
  AST_PREOP_SDO: assert property (i_srv_valid && o_state == 2'h1 && i_srv_kind == SRV_SDO
    |=> o_srv_ack && o_sdo_valid && !o_srv_refused)
    else $error("sdo not served");
  AST_GATE_OFF: assert property (i_srv_valid && (o_state == 2'h0 || o_state == 2'h3)
    |=> o_srv_refused && !o_srv_ack)
    else $error("service not refused");
  AST_NO_REMAP: assert property (i_srv_valid && i_srv_kind == SRV_REMAP |=> o_srv_refused)
    else $error("remap taken");
  AST_SETP: assert property (i_srv_valid && o_state == 2'h2 && i_srv_kind == SRV_RPDO
    |=> o_setp_valid && o_setp_data == $past(i_srv_data))
    else $error("set point lost");
  AST_TPDO_OPER: assert property (o_tpdo_valid |-> o_state == 2'h2)
    else $error("tpdo outside operational");
  AST_CFG_ENTER: assert property (s_to_cfg |=> o_lss_config)
    else $error("config not entered");
  AST_STORE_ACK: assert property (s_store |=> o_lss_ack)
    else $error("store not answered");
  AST_ID_STORE: assert property (!i_nmt_valid && !(i_lss_valid && i_lss_cmd == LSS_STORE)
    |=> $stable(o_node_id))
    else $error("node id moved without store");
  AST_ID_RANGE: assert property (o_node_id != 7'h00)
    else $error("node id zero");
  AST_RATE_10K: assert property (o_bit_idx == BIT_IDX_10K |=> o_rate_kbps == 10'd10)
    else $error("rate wrong for index 8");
endmodule // cnc_node_monitor
bind cnc_node cnc_node_monitor u_mon (.i_clk_sys, .i_rst, .i_nmt_valid, .i_nmt_cmd, .i_nmt_node,
  .i_lss_valid, .i_lss_cmd, .i_lss_data, .i_srv_valid, .i_srv_kind, .i_srv_data, .o_lss_ack,
  .o_srv_ack, .o_srv_refused, .o_setp_valid, .o_setp_data, .o_sdo_valid, .o_tpdo_valid, .o_state,
  .o_lss_config, .o_node_id, .o_bit_idx, .o_rate_kbps);
`default_nettype wire

// *** sim/cnc_master_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Far side stand-in: takes transmit words, at half rate when slow
module cnc_master_model (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Transmit stream from the node
  input wire logic i_tpdo_valid,
  input wire logic [31:0] i_tpdo_data,
  output logic o_tpdo_ready,
  // Mode and received words
  input wire logic i_slow,
  output logic o_got,
  output logic [31:0] o_got_data
);
  // Ready toggles when slow, so the node sees stalls mid-burst
  always_ff @(posedge i_clk_sys) begin
    o_tpdo_ready <= !i_rst && (!i_slow || !o_tpdo_ready);
    o_got <= !i_rst && i_tpdo_valid && o_tpdo_ready;
    o_got_data <= i_tpdo_data;
  end
endmodule // cnc_master_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import cnc_pkg::*;
  // Identity values are arbitrary
  localparam logic [31:0] VEND = 32'h0000_0c31;
  localparam logic [31:0] PROD = 32'h0000_0e02;
  localparam logic [31:0] REVN = 32'h0002_0003;
  localparam logic [31:0] SER = 32'h0004_d2a7;
  localparam logic [9:0] RATES [9] = '{10'd1000, 10'd800, 10'd500, 10'd250, 10'd125, 10'd100, 10'd50, 10'd20, 10'd10};
  logic i_clk_sys = 1'b0, i_rst = 1'b1, i_nmt_valid = 1'b0, i_lss_valid = 1'b0, i_srv_valid = 1'b0;
  logic i_meas_valid = 1'b0, i_tpdo_ready, got;
  logic [7:0] i_nmt_cmd = 8'h00, i_lss_cmd = 8'h00, o_lss_status;
  logic [6:0] i_nmt_node = 7'h00, o_node_id;
  logic [1:0] i_srv_kind = 2'h0, o_state;
  logic [31:0] i_serial = SER, i_lss_data = 32'h0, i_srv_data = 32'h0, i_meas_data = 32'h0, got_data;
  logic [31:0] o_tpdo_data, o_setp_data, o_sdo_data;
  logic o_lss_ack, o_srv_ack, o_srv_refused, o_meas_ready, o_tpdo_valid, o_setp_valid, o_sdo_valid, o_lss_config;
  logic [3:0] o_bit_idx;
  logic [9:0] o_rate_kbps;
  int errors = 0, n_compared = 0, nrx = 0, k;
  cnc_node #(.VENDOR_ID(VEND), .PRODUCT_CODE(PROD), .REVISION(REVN)) DUT (.i_clk_sys, .i_rst, .i_serial,
    .i_nmt_valid, .i_nmt_cmd, .i_nmt_node, .i_lss_valid, .i_lss_cmd, .i_lss_data, .o_lss_ack, .o_lss_status,
    .i_srv_valid, .i_srv_kind, .i_srv_data, .o_srv_ack, .o_srv_refused, .i_meas_valid, .o_meas_ready,
    .i_meas_data, .o_tpdo_valid, .i_tpdo_ready, .o_tpdo_data, .o_setp_valid, .o_setp_data, .o_sdo_valid,
    .o_sdo_data, .o_state, .o_lss_config, .o_node_id, .o_bit_idx, .o_rate_kbps);
  cnc_master_model u_master (.i_clk_sys, .i_rst, .i_tpdo_valid(o_tpdo_valid), .i_tpdo_data(o_tpdo_data),
    .o_tpdo_ready(i_tpdo_ready), .i_slow(1'b1), .o_got(got), .o_got_data(got_data));
  // 25 MHz clock
  initial forever #20 i_clk_sys = ~i_clk_sys;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Drained words must come out in push order
  always @(posedge i_clk_sys) if (got === 1'b1) begin
    chk(got_data, 32'h100 + nrx);
    nrx++;
  end
  // One-cycle request pulses; answers are registered on the taking edge and read 1 ns after it
  task automatic nmt(input logic [7:0] c, input logic [6:0] n, input logic [1:0] s);
    @(posedge i_clk_sys); i_nmt_valid <= 1'b1; i_nmt_cmd <= c; i_nmt_node <= n;
    @(posedge i_clk_sys); i_nmt_valid <= 1'b0;
    #1 chk(o_state, s);
  endtask
  task automatic srv(input logic [1:0] kd, input logic ok);
    // SDO and RPDO payloads differ, so no SDO write shadows a set point
    @(posedge i_clk_sys); i_srv_valid <= 1'b1; i_srv_kind <= kd; i_srv_data <= 32'h5a00 + kd;
    @(posedge i_clk_sys); i_srv_valid <= 1'b0;
    #1 chk(o_srv_ack, ok);
    chk(o_srv_refused, !ok);
    chk(o_sdo_valid, ok && kd == SRV_SDO);
    chk(o_setp_valid, ok && kd == SRV_RPDO);
    if (ok && kd == SRV_SDO) chk(o_sdo_data, 32'h5a00);
  endtask
  task automatic lss(input logic [7:0] c, input logic [31:0] d, input logic ak, input logic [7:0] st);
    @(posedge i_clk_sys); i_lss_valid <= 1'b1; i_lss_cmd <= c; i_lss_data <= d;
    @(posedge i_clk_sys); i_lss_valid <= 1'b0;
    #1 chk(o_lss_ack, ak);
    if (ak) chk(o_lss_status, st);
  endtask
  task automatic t_boot;
    chk(o_state, 2'h0);
    chk(o_node_id, NODE_ID_DEFAULT);
    chk(o_rate_kbps, 10'd10);
    srv(SRV_SDO, 1'b0);
    nmt(NMT_START, 7'h00, 2'h0);
    repeat (20) @(posedge i_clk_sys);
    #1 chk(o_state, 2'h1);
    for (k = 0; k < 4; k++) srv(k[1:0], k == 0);
  endtask
  // Fill the buffer while transmit is closed, then open it against a stalling master
  task automatic t_fifo;
    int n = 0;
    logic acc;
    @(posedge i_clk_sys); i_meas_valid <= 1'b1; i_meas_data <= 32'h100;
    repeat (12) begin
      #1 acc = o_meas_ready;
      @(posedge i_clk_sys);
      if (acc === 1'b1) n++;
      i_meas_data <= 32'h100 + n;
    end
    i_meas_valid <= 1'b0;
    #1 chk(n, 8);
    chk(o_meas_ready, 1'b0);
    chk(o_tpdo_valid, 1'b0);
    nmt(NMT_START, 7'h05, 2'h1);
    nmt(NMT_START, NODE_ID_DEFAULT, 2'h2);
    repeat (30) @(posedge i_clk_sys);
    chk(nrx, 8);
  endtask
  task automatic t_oper;
    for (k = 0; k < 4; k++) srv(k[1:0], k == 0 || k == 2);
    chk(o_setp_data, 32'h5a02);
    nmt(NMT_STOP, 7'h00, 2'h3);
    srv(SRV_SDO, 1'b0);
    nmt(NMT_PREOP, 7'h00, 2'h1);
    nmt(NMT_START, 7'h00, 2'h2);
  endtask
  task automatic t_lss_cfg;
    lss(LSS_CFG_NODE_ID, 32'h71, 1'b0, 8'h00);
    lss(LSS_SWITCH_GLOBAL, 32'h1, 1'b0, 8'h00);
    chk(o_lss_config, 1'b1);
    lss(LSS_CFG_NODE_ID, 32'h0, 1'b1, LSS_ACK_BAD);
    lss(LSS_CFG_NODE_ID, 32'h80, 1'b1, LSS_ACK_BAD);
    lss(LSS_CFG_NODE_ID, 32'h7f, 1'b1, LSS_ACK_OK);
    lss(LSS_CFG_BIT_TIMING, 32'h9, 1'b1, LSS_ACK_BAD);
    chk(o_node_id, NODE_ID_DEFAULT);
    for (k = 0; k < 9; k++) begin
      lss(LSS_CFG_BIT_TIMING, k, 1'b1, LSS_ACK_OK);
      lss(LSS_STORE, 32'h0, 1'b1, LSS_ACK_OK);
      @(posedge i_clk_sys);
      #1 chk(o_rate_kbps, RATES[k]);
      chk(o_bit_idx, k);
    end
    chk(o_node_id, 7'h7f);
    lss(LSS_SWITCH_GLOBAL, 32'h0, 1'b0, 8'h00);
    chk(o_lss_config, 1'b0);
  endtask
  // Selective entry: a wrong serial first, then the right one
  task automatic t_lss_sel;
    for (k = 0; k < 2; k++) begin
      lss(LSS_SEL_VENDOR, VEND, 1'b0, 8'h00);
      lss(LSS_SEL_PRODUCT, PROD, 1'b0, 8'h00);
      lss(LSS_SEL_REVISION, REVN, 1'b0, 8'h00);
      lss(LSS_SEL_SERIAL, k == 0 ? SER ^ 32'h1 : SER, k == 1, LSS_ACK_OK);
      chk(o_lss_config, k == 1);
    end
  endtask
  initial begin
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(posedge i_clk_sys);
    #1 t_boot;
    t_fifo;
    t_oper;
    t_lss_cfg;
    t_lss_sel;
    test_done;
  end
  // Tests need well under 1000 cycles; 3000 means a hang
  initial begin
    #(40 * 3000);
    errors++;
    test_done;
  end
endmodule // testbench
`default_nettype wire
